// file: rtl/asq_pkg.sv
// Package for the converter scan sequence control block.
// Holds register offsets, field positions, reset values and carrier types.
package asq_pkg;

   // Register byte offsets on the plain register port.
   localparam logic [7:0] OFS_CONTROL_TWO = 8'h00;
   localparam logic [7:0] OFS_SCAN_LOW = 8'h04;
   localparam logic [7:0] OFS_SCAN_HIGH = 8'h08;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
   localparam logic [7:0] OFS_CHAN_SEL = 8'h14;

   // Control register field positions.
   localparam int REF_LSB = 13;
   localparam int OFFSET_CAL_ENABLE_BIT = 12;
   localparam int SCAN_EN_BIT = 10;
   localparam int FILL_BIT = 7;
   localparam int CAD_LSB = 2;
   localparam int SPLIT_BIT = 1;
   localparam int ALT_BIT = 0;
   // Writable bits of the control register; bit 7 is read only.
   localparam logic [31:0] CTRL_WR_MASK = 32'h0000_F43F;
   localparam logic [31:0] SCAN_HIGH_MASK = 32'h0007_FFFF;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] SCAN_RESET = 32'h0000_0000;

   // Channel select register: set A in bits 5:0, set B in bits 13:8.
   localparam int CHA_LSB = 0;
   localparam int CHB_LSB = 8;
   localparam logic [31:0] CHAN_WR_MASK = 32'h0000_3F3F;

   // Interrupt status bits.
   localparam int IRQ_CADENCE_BIT = 0;
   localparam int IRQ_WRAP_BIT = 1;
   localparam int IRQ_BITS = 2;

   // Pin count variants and special scan sources.
   localparam int NUM_INPUTS = 51;
   localparam int SMALL_PART_PINS = 64;
   localparam int LARGE_PART_THRESH = 100;
   localparam logic [5:0] SMALL_BANDGAP_IDX = 6'h1C;
   localparam logic [5:0] LARGE_BANDGAP_IDX = 6'h30;

   // Reference pair choices.
   typedef enum logic [1:0] {
      ASQ_REF_SUPPLY,
      ASQ_REF_EXT_HIGH,
      ASQ_REF_EXT_LOW,
      ASQ_REF_EXT_BOTH
   } asq_ref_t;

   // Source routed to the sample-and-hold stage.
   typedef enum logic [1:0] {
      ASQ_SRC_PIN,
      ASQ_SRC_LOW_REF,
      ASQ_SRC_INTERNAL
   } asq_src_kind_t;

   // Routing command to the analog core.
   typedef struct packed {
      logic high_ext;       // High reference is the external pin.
      logic low_ext;        // Low reference is the external pin.
      asq_src_kind_t kind;  // Kind of source on the positive input.
      logic [5:0] index;    // Input index or internal source index.
      logic neg_low_ref;    // Negative input tied to low reference.
      logic mux_b;          // Multiplexer set B in use.
   } asq_route_t;

endpackage

// file: rtl/asq_scan_pick.sv
// Finds the next selected scan input above the current one, with wrap.
// Assumes a 51-bit mask; purely combinational.
`timescale 1ns/10ps
module asq_scan_pick (
   input wire logic [50:0] mask_i,   // Selected inputs.
   input wire logic [5:0] cur_i,     // Current scan index.
   output logic [5:0] next_o,        // Next selected index.
   output logic any_o,               // Any input selected.
   output logic wrap_o               // Next index wrapped to the lowest.
);

   // Descending sweep keeps the lowest index above the current one, else the lowest overall.
   always_comb begin
      logic found_hi;
      logic found_lo;
      logic [5:0] hi_idx;
      logic [5:0] lo_idx;
      found_hi = 1'b0;
      found_lo = 1'b0;
      hi_idx = 6'h00;
      lo_idx = 6'h00;
      for (int i = 50; i >= 0; i--) begin
         if (mask_i[i]) begin
            lo_idx = 6'(i);
            found_lo = 1'b1;
            if (6'(i) > cur_i) begin
               hi_idx = 6'(i);
               found_hi = 1'b1;
            end
         end
      end
      any_o = found_lo;
      wrap_o = found_lo && !found_hi;
      next_o = found_hi ? hi_idx : lo_idx;
   end

endmodule

// file: rtl/asq_ctrl.sv
// Scan sequence and configuration control for the 10-bit converter.
// Assumes a register master on a plain strobe port and an analog core
// that pulses conv_done_i once per finished sample/convert sequence.
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
module asq_ctrl #(
   parameter int PIN_COUNT = 64,             // Package pin count.
   parameter logic [50:0] PIN_PRESENT = '1   // Inputs bonded to pins.
) (
   input wire logic clk_i,                   // Peripheral clock.
   input wire logic reset_n_i,               // Synchronous reset.
   input wire logic [7:0] addr_i,            // Register byte address.
   input wire logic [31:0] wdata_i,          // Write data.
   input wire logic wr_i,                    // Write strobe.
   input wire logic rd_i,                    // Read strobe.
   output logic [31:0] rdata_o,              // Read data, next cycle.
   input wire logic conv_done_i,             // Sequence finished pulse.
   output asq_pkg::asq_route_t route_o,      // Routing to analog core.
   output logic [3:0] slot_o,                // Result slot being filled.
   output logic irq_o                        // Level interrupt.
);

   localparam bit LARGE = PIN_COUNT >= asq_pkg::LARGE_PART_THRESH;

   logic [31:0] ctrl_ff, nxt_ctrl;
   logic [31:0] scan_lo_ff, nxt_scan_lo;
   logic [31:0] scan_hi_ff, nxt_scan_hi;
   logic [31:0] chan_ff, nxt_chan;
   logic [1:0] irq_stat_ff, nxt_irq_stat;
   logic [1:0] irq_mask_ff, nxt_irq_mask;
   logic [31:0] rdata_ff, nxt_rdata;
   logic irq_ff, nxt_irq;

   logic [5:0] scan_idx_ff, nxt_scan_idx;
   logic [3:0] slot_ff, nxt_slot;
   logic [3:0] cad_cnt_ff, nxt_cad_cnt;
   logic use_b_ff, nxt_use_b;
   asq_pkg::asq_route_t route_ff, nxt_route;

   logic [50:0] mask_all;
   logic [5:0] pick_next;
   logic pick_any, pick_wrap;
   logic [2:0] ref_code;
   logic offset_cal_enable, scan_en, split, alt;
   logic [3:0] cadence;

   assign ref_code = ctrl_ff[asq_pkg::REF_LSB +: 3];
   assign offset_cal_enable = ctrl_ff[asq_pkg::OFFSET_CAL_ENABLE_BIT];
   assign scan_en = ctrl_ff[asq_pkg::SCAN_EN_BIT];
   assign split = ctrl_ff[asq_pkg::SPLIT_BIT];
   assign alt = ctrl_ff[asq_pkg::ALT_BIT];
   assign cadence = ctrl_ff[asq_pkg::CAD_LSB +: 4];
   assign mask_all = {scan_hi_ff[18:0], scan_lo_ff};

   // Next selected input, found in ascending order.
   asq_scan_pick u_pick (
      .mask_i(mask_all),
      .cur_i(scan_idx_ff),
      .next_o(pick_next),
      .any_o(pick_any),
      .wrap_o(pick_wrap)
   );

   // Register writes, read mux and interrupt status.
   always_comb begin
      logic [1:0] ev;
      logic [31:0] ctrl_view;
      nxt_ctrl = ctrl_ff;
      nxt_scan_lo = scan_lo_ff;
      nxt_scan_hi = scan_hi_ff;
      nxt_chan = chan_ff;
      nxt_irq_mask = irq_mask_ff;
      nxt_irq_stat = irq_stat_ff;
      nxt_rdata = 32'h0000_0000;
      ev = 2'h0;
      ctrl_view = ctrl_ff;
      ctrl_view[asq_pkg::FILL_BIT] = split & slot_ff[3];
      if (wr_i) begin
         unique case (addr_i)
            asq_pkg::OFS_CONTROL_TWO: begin
               nxt_ctrl = wdata_i & asq_pkg::CTRL_WR_MASK;
            end
            asq_pkg::OFS_SCAN_LOW: nxt_scan_lo = wdata_i;
            asq_pkg::OFS_SCAN_HIGH: begin
               nxt_scan_hi = wdata_i & asq_pkg::SCAN_HIGH_MASK;
            end
            asq_pkg::OFS_IRQ_STATUS: begin
               nxt_irq_stat = irq_stat_ff & ~wdata_i[1:0];
            end
            asq_pkg::OFS_IRQ_MASK: nxt_irq_mask = wdata_i[1:0];
            asq_pkg::OFS_CHAN_SEL: begin
               nxt_chan = wdata_i & asq_pkg::CHAN_WR_MASK;
            end
            default: ;
         endcase
      end
      if (rd_i) begin
         unique case (addr_i)
            asq_pkg::OFS_CONTROL_TWO: nxt_rdata = ctrl_view;
            asq_pkg::OFS_SCAN_LOW: nxt_rdata = scan_lo_ff;
            asq_pkg::OFS_SCAN_HIGH: nxt_rdata = scan_hi_ff;
            asq_pkg::OFS_IRQ_STATUS: nxt_rdata = {30'h0, irq_stat_ff};
            asq_pkg::OFS_IRQ_MASK: nxt_rdata = {30'h0, irq_mask_ff};
            asq_pkg::OFS_CHAN_SEL: nxt_rdata = chan_ff;
            default: nxt_rdata = 32'h0000_0000;
         endcase
      end
      ev[asq_pkg::IRQ_CADENCE_BIT] = conv_done_i && (cad_cnt_ff == cadence);
      ev[asq_pkg::IRQ_WRAP_BIT] = conv_done_i && scan_en && pick_wrap;
      // Set wins over a clear in the same cycle.
      nxt_irq_stat = nxt_irq_stat | ev;
      nxt_irq = |(nxt_irq_stat & nxt_irq_mask);
   end

   // Register state.
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         ctrl_ff <= asq_pkg::CTRL_RESET;
         scan_lo_ff <= asq_pkg::SCAN_RESET;
         scan_hi_ff <= asq_pkg::SCAN_RESET;
         chan_ff <= 32'h0000_0000;
         irq_stat_ff <= 2'h0;
         irq_mask_ff <= 2'h0;
         rdata_ff <= 32'h0000_0000;
         irq_ff <= 1'b0;
      end else begin
         ctrl_ff <= nxt_ctrl;
         scan_lo_ff <= nxt_scan_lo;
         scan_hi_ff <= nxt_scan_hi;
         chan_ff <= nxt_chan;
         irq_stat_ff <= nxt_irq_stat;
         irq_mask_ff <= nxt_irq_mask;
         rdata_ff <= nxt_rdata;
         irq_ff <= nxt_irq;
      end
   end

   // Sequence state: scan position, slot, cadence count, mux set.
   always_comb begin
      nxt_scan_idx = scan_idx_ff;
      nxt_slot = slot_ff;
      nxt_cad_cnt = cad_cnt_ff;
      nxt_use_b = use_b_ff;
      if (!alt) begin
         nxt_use_b = 1'b0;
      end
      if (conv_done_i) begin
         if (scan_en && pick_any) begin
            nxt_scan_idx = pick_next;
         end
         if (split) begin
            nxt_slot = (slot_ff[2:0] == 3'h7) ?
               {~slot_ff[3], 3'h0} : slot_ff + 4'h1;
         end else begin
            nxt_slot = slot_ff + 4'h1;
         end
         nxt_cad_cnt = (cad_cnt_ff >= cadence) ? 4'h0 : cad_cnt_ff + 4'h1;
         nxt_use_b = alt & ~use_b_ff;
      end
   end

   // Routing decode for the next sample.
   always_comb begin
      logic [5:0] idx;
      nxt_route = '0;
      idx = 6'h00;
      unique case (ref_code)
         3'h1: nxt_route.high_ext = 1'b1;
         3'h2: nxt_route.low_ext = 1'b1;
         3'h3: begin
            nxt_route.high_ext = 1'b1;
            nxt_route.low_ext = 1'b1;
         end
         default: ;
      endcase
      nxt_route.mux_b = nxt_use_b;
      if (scan_en) begin
         idx = nxt_scan_idx;
      end else if (nxt_use_b) begin
         idx = chan_ff[asq_pkg::CHB_LSB +: 6];
      end else begin
         idx = chan_ff[asq_pkg::CHA_LSB +: 6];
      end
      nxt_route.index = idx;
      nxt_route.kind = asq_pkg::ASQ_SRC_PIN;
      if (!LARGE && scan_en && idx >= asq_pkg::SMALL_BANDGAP_IDX &&
          idx <= asq_pkg::SMALL_BANDGAP_IDX + 6'h02) begin
         nxt_route.kind = asq_pkg::ASQ_SRC_INTERNAL;
         nxt_route.index = idx - asq_pkg::SMALL_BANDGAP_IDX;
      end else if (LARGE && scan_en && idx >= asq_pkg::LARGE_BANDGAP_IDX &&
          idx <= asq_pkg::LARGE_BANDGAP_IDX + 6'h02) begin
         nxt_route.kind = asq_pkg::ASQ_SRC_INTERNAL;
         nxt_route.index = idx - asq_pkg::LARGE_BANDGAP_IDX;
      end else if (idx > 6'd50 || !PIN_PRESENT[idx] ||
          (!LARGE && idx >= 6'd32)) begin
         nxt_route.kind = asq_pkg::ASQ_SRC_LOW_REF;
      end
      if (offset_cal_enable) begin
         nxt_route.kind = asq_pkg::ASQ_SRC_LOW_REF;
         nxt_route.neg_low_ref = 1'b1;
      end else begin
         nxt_route.neg_low_ref = 1'b1;
      end
   end

   // Sequence registers.
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         scan_idx_ff <= 6'h3F;
         slot_ff <= 4'h0;
         cad_cnt_ff <= 4'h0;
         use_b_ff <= 1'b0;
         route_ff <= '0;
      end else begin
         scan_idx_ff <= nxt_scan_idx;
         slot_ff <= nxt_slot;
         cad_cnt_ff <= nxt_cad_cnt;
         use_b_ff <= nxt_use_b;
         route_ff <= nxt_route;
      end
   end

   assign rdata_o = rdata_ff;
   assign route_o = route_ff;
   assign slot_o = slot_ff;
   assign irq_o = irq_ff;

endmodule

// file: tb/asq_ctrl_props.sv
// Checker for the scan sequence control block, bound into asq_ctrl.
// Sees only the top ports and keeps its own copy of the control word.
`timescale 1ns/10ps
module asq_ctrl_props #(
   parameter int PIN_COUNT = 64,             // Package pin count.
   parameter logic [50:0] PIN_PRESENT = '1   // Inputs bonded to pins.
) (
   input wire logic clk_i,                   // Clock.
   input wire logic reset_n_i,               // Reset, active low.
   input wire logic [7:0] addr_i,            // Address.
   input wire logic [31:0] wdata_i,          // Write data.
   input wire logic wr_i,                    // Write strobe.
   input wire logic rd_i,                    // Read strobe.
   input wire logic [31:0] rdata_o,          // Read data.
   input wire logic conv_done_i,             // Sequence finished.
   input wire asq_pkg::asq_route_t route_o,  // Routing.
   input wire logic [3:0] slot_o,            // Slot being filled.
   input wire logic irq_o                    // Interrupt.
);
   logic [31:0] ctl_ff;
   logic ctl_wr;
   assign ctl_wr = wr_i && addr_i == asq_pkg::OFS_CONTROL_TWO;
   // Shadow of the control word, so routing can be judged from the port.
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         ctl_ff <= '0;
      end else if (ctl_wr) begin
         ctl_ff <= wdata_i;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   a_rdata_idle: assert property (!rd_i |=> rdata_o == '0)
      else $error("read data not zero outside a read answer");
   a_ctrl_reserved: assert property (rd_i && !wr_i && ctl_wr == 1'b0 &&
      addr_i == asq_pkg::OFS_CONTROL_TWO |=> (rdata_o & 32'hFFFF_0B40) == '0)
      else $error("unimplemented control bits read nonzero");
   a_fill_status: assert property (rd_i &&
      addr_i == asq_pkg::OFS_CONTROL_TWO |=>
      rdata_o[7] == (rdata_o[1] && $past(slot_o[3])))
      else $error("fill status does not match slot half");
   a_slot_step: assert property (conv_done_i && !wr_i |=>
      slot_o == $past(slot_o) + 4'h1)
      else $error("slot did not advance by one");
   a_ref_decode: assert property ($past(reset_n_i) && !$past(ctl_wr) |->
      route_o.high_ext == (!ctl_ff[15] && ctl_ff[13]) &&
      route_o.low_ext == (!ctl_ff[15] && ctl_ff[14]))
      else $error("reference pair wrong for code");
   a_offset_cal_enable_route: assert property ($past(reset_n_i) &&
      !$past(ctl_wr) && ctl_ff[12] |->
      route_o.kind == asq_pkg::ASQ_SRC_LOW_REF && route_o.neg_low_ref)
      else $error("offset calibration routing wrong");
   a_alt_toggle: assert property (conv_done_i && ctl_ff[0] && !ctl_wr
      |=> route_o.mux_b != $past(route_o.mux_b))
      else $error("multiplexer set did not alternate");
   a_irq_cause: assert property ($rose(irq_o) |->
      $past(conv_done_i) || $past(wr_i))
      else $error("interrupt rose without a cause");
   c_irq: cover property ($rose(irq_o));
   c_fill: cover property (rd_i && slot_o[3]);
   c_alt: cover property (conv_done_i && ctl_ff[0]);
endmodule
bind asq_ctrl asq_ctrl_props #(.PIN_COUNT(PIN_COUNT),
   .PIN_PRESENT(PIN_PRESENT)) u_props (.clk_i(clk_i), .reset_n_i(reset_n_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
   .rdata_o(rdata_o), .conv_done_i(conv_done_i), .route_o(route_o),
   .slot_o(slot_o), .irq_o(irq_o));

// file: tb/asq_core_model.sv
// Model of the analog sample-and-hold and conversion core.
// Answers each start pulse taken while idle with one finished-sequence pulse.
`timescale 1ns/10ps
module asq_core_model (
   input wire logic clk_i,       // Clock.
   input wire logic reset_n_i,   // Reset, active low.
   input wire logic start_i,     // Start one sequence.
   input wire logic slow_i,      // Long conversion time.
   output logic conv_done_o      // Sequence finished pulse.
);
   logic [2:0] cnt_ff;
   // Slow answers leave idle cycles, so outputs must hold meanwhile.
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         cnt_ff <= 3'h0;
         conv_done_o <= 1'b0;
      end else begin
         conv_done_o <= cnt_ff == 3'h1;
         if (start_i && cnt_ff == 3'h0) begin
            cnt_ff <= slow_i ? 3'h5 : 3'h1;
         end else if (cnt_ff != 3'h0) begin
            cnt_ff <= cnt_ff - 3'h1;
         end
      end
   end
endmodule

// file: tb/test_asq_ctrl.sv
// Self-checking bench for the scan sequence control block.
// Drives the register port and a core model; the checker is bound in.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin \
   $display("mismatch %s exp %0h got %0h", nm, ex, got); n_errors++; end end
module test_asq_ctrl;
   localparam logic [7:0] CTL = asq_pkg::OFS_CONTROL_TWO;
   localparam logic [7:0] MSK = asq_pkg::OFS_IRQ_MASK;
   localparam logic [7:0] STS = asq_pkg::OFS_IRQ_STATUS;
   typedef struct packed {
      logic [7:0] a;
      logic [31:0] e;
   } asq_row_t;
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic start = 1'b0;
   logic slow = 1'b0;
   logic conv_done;
   logic [31:0] rdata_o, d;
   asq_pkg::asq_route_t route_o;
   logic [3:0] slot_o;
   logic irq_o;
   int n_errors = 0;
   int checks = 0;
   int i, k, n;
   int cad [3] = '{0, 7, 15};
   asq_row_t rows [7] = '{'{CTL, asq_pkg::CTRL_WR_MASK},
      '{asq_pkg::OFS_SCAN_LOW, 32'hFFFF_FFFF}, '{STS, 32'h0},
      '{asq_pkg::OFS_SCAN_HIGH, asq_pkg::SCAN_HIGH_MASK}, '{MSK, 32'h3},
      '{asq_pkg::OFS_CHAN_SEL, asq_pkg::CHAN_WR_MASK}, '{8'h40, 32'h0}};
   asq_pkg::asq_src_kind_t sk [6] = '{asq_pkg::ASQ_SRC_PIN,
      asq_pkg::ASQ_SRC_INTERNAL, asq_pkg::ASQ_SRC_INTERNAL,
      asq_pkg::ASQ_SRC_INTERNAL, asq_pkg::ASQ_SRC_LOW_REF, asq_pkg::ASQ_SRC_PIN};
   logic [5:0] si [6] = '{6'h03, 6'h00, 6'h01, 6'h02, 6'h00, 6'h03};
   always #4 clk_i = ~clk_i;
   asq_ctrl dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .conv_done_i(conv_done), .route_o(route_o), .slot_o(slot_o),
      .irq_o(irq_o));
   asq_core_model u_core (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .start_i(start), .slow_i(slow), .conv_done_o(conv_done));
   // Register port cycles; each ends on the edge that takes the strobe, a read 1 ns after it.
   task automatic wr(input logic [7:0] a, input logic [31:0] w);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= w;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask
   task automatic settle();
      repeat (2) @(posedge clk_i);
      #1;
   endtask
   // One sequence; prompt and slow answers alternate.
   task automatic conv();
      @(posedge clk_i);
      start <= 1'b1;
      slow <= ~slow;
      @(posedge clk_i);
      start <= 1'b0;
      for (n = 0; n < 12 && conv_done !== 1'b1; n++) @(posedge clk_i);
      #1;
   endtask
   task automatic do_reset();
      @(posedge clk_i);
      reset_n_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      reset_n_i <= 1'b1;
   endtask
   task automatic complete_run();
      if (n_errors == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // The run needs a few hundred cycles; this leaves a wide margin.
   initial begin
      #200000;
      n_errors++;
      complete_run();
   end
   initial begin
      do_reset();
      foreach (rows[j]) begin
         rd(rows[j].a);
         `CHK("reset value", 32'h0, d)
         wr(rows[j].a, '1);
         rd(rows[j].a);
         `CHK("readback", rows[j].e, d)
      end
      do_reset();
      for (i = 0; i < 8; i++) begin
         wr(CTL, 32'(i) << asq_pkg::REF_LSB);
         settle();
         `CHK("high ref", !i[2] && i[0], route_o.high_ext)
         `CHK("low ref", !i[2] && i[1], route_o.low_ext)
      end
      wr(CTL, 32'h0000_1000);
      settle();
      `CHK("offset_cal_enable kind", asq_pkg::ASQ_SRC_LOW_REF, route_o.kind)
      `CHK("negative input", 1'b1, route_o.neg_low_ref)
      // Set A is taken first, then B and A alternate per sequence.
      wr(asq_pkg::OFS_CHAN_SEL, 32'h0000_0905);
      wr(CTL, 32'h0000_0001);
      settle();
      for (i = 0; i < 4; i++) begin
         `CHK("fixed kind", asq_pkg::ASQ_SRC_PIN, route_o.kind)
         `CHK("mux set", i[0], route_o.mux_b)
         `CHK("fixed index", i[0] ? 6'h09 : 6'h05, route_o.index)
         conv();
      end
      wr(CTL, 32'h0);
      conv();
      `CHK("alt off", 1'b0, route_o.mux_b)
      // Inputs 3, 28-30 and 32 are scanned on a 64-pin part.
      do_reset();
      wr(asq_pkg::OFS_SCAN_LOW, 32'h7000_0008);
      wr(asq_pkg::OFS_SCAN_HIGH, 32'h0000_0001);
      wr(CTL, 32'h0000_0400);
      for (i = 0; i < 6; i++) begin
         conv();
         `CHK("scan kind", sk[i], route_o.kind)
         if (i != 4) `CHK("scan index", si[i], route_o.index)
      end
      rd(STS);
      `CHK("status", 32'h3, d)
      foreach (cad[j]) begin
         do_reset();
         wr(MSK, 32'h1);
         wr(CTL, (32'(cad[j]) << asq_pkg::CAD_LSB) | 32'h2);
         k = 0;
         while (irq_o !== 1'b1 && k < 20) begin
            conv();
            k++;
            `CHK("slot", k[3:0], slot_o)
         end
         `CHK("cadence", cad[j] + 1, k)
         rd(CTL);
         `CHK("fill", k[3], d[asq_pkg::FILL_BIT])
         wr(MSK, 32'h0);
         settle();
         `CHK("masked", 1'b0, irq_o)
         wr(MSK, 32'h1);
         settle();
         `CHK("unmasked", 1'b1, irq_o)
         wr(STS, 32'h1);
         settle();
         `CHK("cleared", 1'b0, irq_o)
      end
      complete_run();
   end
endmodule
